// ### core/odsl_core.sv
// Serial load and control logic of an eight-channel voltage-output converter.
// Assumes all pins are asynchronous to mclk_i and are synchronised here.
// Frame field decoding and the analog side lie outside this module.
// Notes on behaviour
// (R1) Frame select low, then 24 serial clock falling edges form one frame.
// (R2) Serial data is sampled on serial clock falling edges.
// (R3) Host keeps the serial clock at or below 50 MHz; here each serial clock level must last at least one 25 MHz mclk_i period.
// (R4) A 24-bit input shift register holds each frame.
// (R5) Span strap low gives one times reference, high gives two times.
// (R6) Power-on level strap picks zero scale or midscale at power-up.
// (R7) Load strobe low copies pending input registers into channel registers.
// (R8) Load strobe may pulse or stay low for synchronous updating.
// (R9) Serial output changes on serial clock rising edges.
// (R10) Serial output carries daisy-chain bits or readback data.
// (R11) A falling edge on the reset pin starts reset, without serial clock.
// (R12) Load strobe pulses are ignored while the reset pin is low.
// (R13) Reset loads input and channel registers with the strap-selected level.
// (R14) Frames act only after 24 edges and frame select rising; short frames drop.
// (R15) Full frame goes to an outside decoder choosing the input register.
`default_nettype none
module odsl_core (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic sclk_i,
    input wire logic sync_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic sdo_oe_o,
    input wire logic load_strobe_n_i,
    input wire logic reset_n_i,
    input wire logic power_on_level_select_i,
    input wire logic span_select_i,
    output logic span_double_o,
    output logic frame_valid_o,
    input wire logic frame_ready_i,
    output logic [23:0] frame_data_o,
    input wire logic wr_en_i,
    input wire logic [2:0] wr_chan_i,
    input wire logic [15:0] wr_code_i,
    input wire logic readback_en_i,
    input wire logic [2:0] readback_chan_i,
    output logic [127:0] chan_code_o
);
    // Synchroniser stages, one pair per pin
    logic [1:0] sclk_sy;
    logic [1:0] sync_sy;
    logic [1:0] sdi_sy;
    logic [1:0] load_strobe_n_sy;
    logic [1:0] rstn_sy;
    logic [1:0] pols_sy;
    logic [1:0] span_sy;
    // Edge history and detected edges
    logic sclk_d;
    logic rstn_d;
    logic sclk_fall;
    logic sclk_rise;
    logic reset_fall;
    // Frame state and shift registers
    odsl_pkg::odsl_state_e state;
    odsl_pkg::odsl_state_e next_state;
    logic [23:0] shift;
    logic [4:0] bit_cnt;
    logic [23:0] out_shift;
    logic out_load;
    // Input and channel registers with their load bookkeeping
    logic [15:0] in_reg [8];
    logic [15:0] dac_reg [8];
    logic [7:0] pending;
    logic level_rst;
    logic [15:0] rst_level;
    // Counts down after rst_i so the strap is settled before the power-up load
    logic [1:0] boot_cnt;
    logic power_up;

    odsl_stream_if #(.W(odsl_pkg::FRAME_BITS)) frame_s ();

    // Two-stage synchronisers on every pin; first stage feeds only the second.
    // Reset values equal the idle pin levels, so no false edge or false frame
    // start is seen in the first cycles after reset.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_sy <= 2'h0;
            sync_sy <= 2'h3;
            sdi_sy <= 2'h0;
            load_strobe_n_sy <= 2'h3;
            rstn_sy <= 2'h3;
            pols_sy <= 2'h0;
            span_sy <= 2'h0;
        end else if (ce_i) begin
            sclk_sy <= {sclk_sy[0], sclk_i};
            sync_sy <= {sync_sy[0], sync_n_i};
            sdi_sy <= {sdi_sy[0], sdi_i};
            load_strobe_n_sy <= {load_strobe_n_sy[0], load_strobe_n_i};
            rstn_sy <= {rstn_sy[0], reset_n_i};
            pols_sy <= {pols_sy[0], power_on_level_select_i};
            span_sy <= {span_sy[0], span_select_i};
        end
    end

    // Serial clock history; parked low at reset, matching the idle link,
    // so the first frame after reset does not start with a phantom edge
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_d <= 1'b0;
        end else if (ce_i) begin
            sclk_d <= sclk_sy[1];
        end
    end

    // Reset pin history; parked high so only a real falling edge starts a
    // level reset, never the release of rst_i itself
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rstn_d <= 1'b1;
        end else if (ce_i) begin
            rstn_d <= rstn_sy[1];
        end
    end

    // Edge strobes last one cycle; the straps are only passed through
    assign sclk_fall = sclk_d && !sclk_sy[1]; // R2
    assign sclk_rise = !sclk_d && sclk_sy[1]; // R9
    assign reset_fall = rstn_d && !rstn_sy[1]; // R11
    assign span_double_o = span_sy[1]; // R5
    assign rst_level = pols_sy[1] ? odsl_pkg::MID_SCALE : odsl_pkg::ZERO_SCALE; // R6
    // Power-up and pin reset both restore the strap level. rst_i alone clears to
    // zero scale, so the power-up load waits until the strap has passed its
    // synchroniser and then fires exactly once.
    assign power_up = boot_cnt == 2'h1; // R6
    assign level_rst = reset_fall || power_up; // R6 R13

    // Power-up sequencer: the strap level is trusted from the third edge after
    // rst_i release; a clock enable held low simply delays the load
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            boot_cnt <= odsl_pkg::SYNC_DEPTH + 2'h1;
        end else if (ce_i) begin
            if (boot_cnt != 2'h0) begin
                boot_cnt <= boot_cnt - 2'h1;
            end
        end
    end

    // Frame state: idle until select falls, shift 24 bits, wait for select rise.
    // Extra falling edges after the 24th are ignored in the done state, and a
    // rise of frame select before the 24th edge drops the frame.
    always_comb begin
        next_state = state;
        case (state)
            odsl_pkg::ODSL_IDLE: begin
                if (!sync_sy[1]) begin
                    next_state = odsl_pkg::ODSL_SHIFT; // R1
                end
            end
            odsl_pkg::ODSL_SHIFT: begin
                if (sync_sy[1]) begin
                    next_state = odsl_pkg::ODSL_IDLE; // R14
                end else if (sclk_fall && bit_cnt == odsl_pkg::FRAME_COUNT - 5'h1) begin
                    next_state = odsl_pkg::ODSL_DONE;
                end
            end
            odsl_pkg::ODSL_DONE: begin
                if (sync_sy[1]) begin
                    next_state = odsl_pkg::ODSL_IDLE;
                end
            end
            default: next_state = odsl_pkg::ODSL_IDLE;
        endcase
    end

    // State register; a low clock enable holds the frame where it is
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= odsl_pkg::ODSL_IDLE;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    // Input shift register, MSB first. A frame cut short leaves partial bits here,
    // which is harmless: only a frame that reached the done state is offered on.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            shift <= '0;
        end else if (ce_i) begin
            if (state == odsl_pkg::ODSL_SHIFT && sclk_fall) begin
                shift <= {shift[odsl_pkg::FRAME_BITS-2:0], sdi_sy[1]}; // R2 R4
            end
        end
    end

    // Bit count of the frame in progress; cleared while idle so a cut frame
    // cannot leave a stale count behind for the next one
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt <= 5'h00;
        end else if (ce_i) begin
            if (state == odsl_pkg::ODSL_IDLE) begin
                bit_cnt <= 5'h00;
            end else if (state == odsl_pkg::ODSL_SHIFT && sclk_fall) begin
                bit_cnt <= bit_cnt + 5'h01; // R1
            end
        end
    end

    // Offer a complete frame once select rises; a full FIFO drops the frame.
    // Valid lasts one cycle, since the state returns to idle on that same edge.
    assign frame_s.valid = ce_i && state == odsl_pkg::ODSL_DONE && sync_sy[1]; // R14
    assign frame_s.data = shift;

    // Sixteen frames of slack let the decoder stall without losing back-to-back frames
    odsl_fifo #(.WIDTH(odsl_pkg::FRAME_BITS), .DEPTH(odsl_pkg::FIFO_DEPTH)) u_fifo (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_s(frame_s),
        .out_valid_o(frame_valid_o),
        .out_ready_i(frame_ready_i),
        .out_data_o(frame_data_o)
    ); // R15

    // Serial output word: at frame start either the readback word is loaded or the
    // previous frame stays in place, so the chain sees a fixed 24-bit delay.
    // The load is open for one cycle only, the idle cycle in which select is seen low.
    assign out_load = ce_i && state == odsl_pkg::ODSL_IDLE && !sync_sy[1];
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            out_shift <= '0;
        end else if (ce_i) begin
            if (out_load && readback_en_i) begin
                out_shift <= {8'h00, in_reg[readback_chan_i]}; // R10
            end else if (state == odsl_pkg::ODSL_SHIFT && sclk_fall) begin
                out_shift <= {out_shift[odsl_pkg::FRAME_BITS-2:0], sdi_sy[1]}; // R10
            end
        end
    end

    // Serial output pin changes only on a seen rising edge, giving the host most
    // of the high half period to sample it on the following falling edge
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sdo_o <= 1'b0;
        end else if (ce_i) begin
            if (sclk_rise && state != odsl_pkg::ODSL_IDLE) begin
                sdo_o <= out_shift[odsl_pkg::FRAME_BITS-1]; // R9
            end
        end
    end
    // Drive the pin only inside a frame so several devices can share the host input
    assign sdo_oe_o = !sync_sy[1]; // R10

    // Per-channel input and channel registers with pending flags. Each channel
    // keeps its own pending bit so one strobe updates only channels written since
    // the last load, and all of them on the same edge.
    for (genvar c = 0; c < odsl_pkg::CHANNELS; c++) begin : g_chan
        logic hit;
        logic load;
        assign hit = wr_en_i && wr_chan_i == 3'(c);
        // Strobe level, not edge: a strobe held low loads every write one cycle later
        assign load = !load_strobe_n_sy[1] && rstn_sy[1] && pending[c]; // R7 R8 R12

        // Input register: decoder writes, strap level on pin reset or power-up
        always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
                in_reg[c] <= odsl_pkg::ZERO_SCALE;
            end else if (ce_i) begin
                if (level_rst) begin
                    in_reg[c] <= rst_level; // R13
                end else if (hit) begin
                    in_reg[c] <= wr_code_i; // R15
                end
            end
        end

        // Channel register: copies the input register only on a load
        always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
                dac_reg[c] <= odsl_pkg::ZERO_SCALE;
            end else if (ce_i) begin
                if (level_rst) begin
                    dac_reg[c] <= rst_level; // R13
                end else if (load) begin
                    dac_reg[c] <= in_reg[c]; // R7
                end
            end
        end

        // Pending flag: a write in the load cycle wins over the clear, so the new
        // code waits for the next load instead of being lost. A level reset
        // discards everything, including a write in that same cycle.
        always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
                pending[c] <= 1'b0;
            end else if (ce_i) begin
                if (level_rst) begin
                    pending[c] <= 1'b0;
                end else begin
                    pending[c] <= hit || (pending[c] && !load);
                end
            end
        end
        assign chan_code_o[c*odsl_pkg::CODE_BITS +: odsl_pkg::CODE_BITS] = dac_reg[c];
    end
endmodule // odsl_core
`default_nettype wire

// ### core/odsl_fifo.sv
// Frame FIFO with valid/ready on both sides and honest full and empty.
// Assumes one clock; clock enable freezes all state.
`default_nettype none
module odsl_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    odsl_stream_if.snk in_s,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic full;
    logic empty;

    // Pointers carry one extra bit to tell full from empty
    assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    assign in_s.ready = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr[AW-1:0]];

    // Storage holds no reset, only pointers do
    always_ff @(posedge mclk_i) begin
        if (ce_i && in_s.valid && !full) begin
            mem[wr_ptr[AW-1:0]] <= in_s.data;
        end
    end

    // Pointer updates
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (ce_i) begin
            if (in_s.valid && !full) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_ready_i && !empty) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // odsl_fifo
`default_nettype wire

// ### core/odsl_pkg.sv
// Constants shared by the octal converter serial load and control logic.
// Assumes a single system clock mclk_i at 25 MHz samples every pin.
`default_nettype none
package odsl_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CHANNELS = 8;
    localparam int CODE_BITS = 16;
    localparam int CNT_BITS = 5;
    localparam int CHAN_BITS = 3;
    localparam int FIFO_DEPTH = 16;
    // Frame layout handed to the decoder: [23:20] command, [19:16] address, [15:0] code
    localparam int CODE_LSB = 0;
    localparam int ADDR_LSB = 16;
    localparam int CMD_LSB = 20;
    localparam logic [4:0] FRAME_COUNT = 5'h18;
    localparam logic [15:0] ZERO_SCALE = 16'h0000;
    localparam logic [15:0] MID_SCALE = 16'h8000;
    // Highest serial clock the host may use, and the rate of our own clock
    localparam int SCLK_MAX_MHZ = 50;
    localparam int MCLK_MHZ = 25;
    localparam logic [1:0] SYNC_DEPTH = 2'h2;
    typedef enum logic [1:0] {
        ODSL_IDLE = 2'b00,
        ODSL_SHIFT = 2'b01,
        ODSL_DONE = 2'b11
    } odsl_state_e;
endpackage
`default_nettype wire

// ### core/odsl_stream_if.sv
// Frame stream carrier between the serial front end and the frame FIFO.
// Assumes both ends run on mclk_i.
`default_nettype none
interface odsl_stream_if #(parameter int W = 24);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ### dv/odsl_chk.sv
// Checker on the core's pins: frame hand-off, serial output timing, load and reset.
// Assumes it is bound onto odsl_core and the straps stay steady around resets.
`default_nettype none
module odsl_chk (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic sync_n_i,
    input wire logic sdo_o,
    input wire logic sdo_oe_o,
    input wire logic load_strobe_n_i,
    input wire logic reset_n_i,
    input wire logic power_on_level_select_i,
    input wire logic span_select_i,
    input wire logic span_double_o,
    input wire logic frame_valid_o,
    input wire logic frame_ready_i,
    input wire logic [23:0] frame_data_o,
    input wire logic [127:0] chan_code_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic [2:0] quiet;
    // Cycles since a strobe, a pin reset or rst_i; saturates so it never wraps.
    // rst_i counts because the power-up load follows its release.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i)
            quiet <= 3'h0;
        else if (!load_strobe_n_i || !reset_n_i)
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;
    end
    property p_frame; $rose(frame_valid_o) |-> $past(sync_n_i, 2) && !$past(sync_n_i, 8);
    endproperty
    property p_stand; frame_valid_o && !frame_ready_i |=> frame_valid_o && $stable(frame_data_o);
    endproperty
    property p_sdo; (!sclk_i && !sync_n_i) [*8] |=> $stable(sdo_o); endproperty
    property p_oe_off; sync_n_i [*5] |-> !sdo_oe_o; endproperty
    property p_oe_on; !sync_n_i [*5] |-> sdo_oe_o; endproperty
    property p_span; $stable(span_select_i) [*5] |-> span_double_o == span_select_i; endproperty
    property p_lvl; $fell(reset_n_i) |-> ##[3:8] chan_code_o ==
        {8{power_on_level_select_i ? odsl_pkg::MID_SCALE : odsl_pkg::ZERO_SCALE}}; endproperty
    property p_hold; !reset_n_i [*6] |=> $stable(chan_code_o); endproperty
    property p_load; $changed(chan_code_o) |-> quiet < 3'h6; endproperty
    a_frame: assert property (p_frame) else $error("frame without select rise");
    a_stand: assert property (p_stand) else $error("head frame moved");
    a_sdo: assert property (p_sdo) else $error("sdo moved without clock rise");
    a_oe_off: assert property (p_oe_off) else $error("sdo driven while idle");
    a_oe_on: assert property (p_oe_on) else $error("sdo not driven in frame");
    a_span: assert property (p_span) else $error("span strap not followed");
    a_lvl: assert property (p_lvl) else $error("reset level wrong");
    a_hold: assert property (p_hold) else $error("channels moved in reset");
    a_load: assert property (p_load) else $error("channels moved without strobe");
    c_frame: cover property ($rose(frame_valid_o));
    c_reset: cover property ($fell(reset_n_i));
    c_load: cover property ($changed(chan_code_o));
endmodule // odsl_chk
`default_nettype wire

// ### dv/odsl_core_tb.sv
// Bench for the serial load and control core, with host model and bound checker.
// Assumes design files, checker and host model are compiled before it.
`default_nettype none
bind odsl_core odsl_chk u_chk (.mclk_i, .rst_i, .sclk_i, .sync_n_i, .sdo_o, .sdo_oe_o,
    .load_strobe_n_i, .reset_n_i, .power_on_level_select_i, .span_select_i, .span_double_o,
    .frame_valid_o, .frame_ready_i, .frame_data_o, .chan_code_o);
module odsl_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, ld_n = 1'b1, rpin_n = 1'b1, lvl = 1'b0;
    logic span = 1'b0;
    logic sclk, sync_n, sdi, sdo, oe, span2, fv, fr = 1'b0, we = 1'b0, rb = 1'b0;
    logic [2:0] wc = 3'h0, rbc = 3'h0;
    logic [15:0] wd = 16'h0000;
    logic [23:0] fd, rx;
    logic [127:0] chan;
    int failures = 0, n_tests = 0;
    odsl_core DUT (.mclk_i(mclk), .rst_i(rst), .ce_i(ce), .sclk_i(sclk), .sync_n_i(sync_n),
        .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(oe), .load_strobe_n_i(ld_n), .reset_n_i(rpin_n),
        .power_on_level_select_i(lvl), .span_select_i(span), .span_double_o(span2),
        .frame_valid_o(fv), .frame_ready_i(fr), .frame_data_o(fd), .wr_en_i(we),
        .wr_chan_i(wc), .wr_code_i(wd), .readback_en_i(rb), .readback_chan_i(rbc),
        .chan_code_o(chan));
    // An undriven output line shows the inverse of its last bit to the host
    odsl_host h (.sclk_o(sclk), .sync_n_o(sync_n), .sdi_o(sdi), .sdo_i(oe ? sdo : ~sdo));
    // 25 MHz system clock
    always #20 mclk = ~mclk;
    task automatic chk(input string nm, input logic [127:0] got, input logic [127:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [2:0] c, input logic [15:0] d);
        @(posedge mclk);
        we <= 1'b1;
        wc <= c;
        wd <= d;
        @(posedge mclk);
        we <= 1'b0;
    endtask
    // Head frame must match, then one pop
    task automatic pop(input logic [23:0] e);
        chk("valid", fv, 1'b1);
        chk("frame", fd, e);
        cyc(1);
        fr <= 1'b1;
        cyc(1);
        fr <= 1'b0;
        cyc(1);
        #1;
    endtask
    task automatic strobe(input int n);
        cyc(1);
        ld_n <= 1'b0;
        cyc(n);
        ld_n <= 1'b1;
    endtask
    initial begin
        cyc(20);
        rst <= 1'b0;
        cyc(2);
        // Back to back frames; the second returns the first on the chain output
        h.xfer(24'h31abcd, 24, rx);
        h.xfer(24'h7e0142, 24, rx);
        chk("chain", rx, 24'h31abcd);
        pop(24'h31abcd);
        pop(24'h7e0142);
        h.xfer(24'h123456, 23, rx);
        chk("short", fv, 1'b0);
        $display("frame tests done");
        // Fill past depth with the decoder stalled, then drain in order
        for (int i = 0; i < 17; i++)
            h.xfer(24'h300000 + 24'(i), 24, rx);
        for (int i = 0; i < 16; i++)
            pop(24'h300000 + 24'(i));
        chk("drained", fv, 1'b0);
        $display("fifo test done");
        // Pin reset to midscale; strobe ignored while low; then zero scale
        cyc(1);
        lvl <= 1'b1;
        cyc(4);
        rpin_n <= 1'b0;
        cyc(10);
        #1 chk("mid", chan, {8{odsl_pkg::MID_SCALE}});
        wr(3'h2, 16'h1234);
        strobe(4);
        cyc(8);
        #1 chk("ignored", chan, {8{odsl_pkg::MID_SCALE}});
        cyc(1);
        rpin_n <= 1'b1;
        lvl <= 1'b0;
        cyc(4);
        rpin_n <= 1'b0;
        cyc(10);
        #1 chk("zero", chan, {8{odsl_pkg::ZERO_SCALE}});
        cyc(1);
        rpin_n <= 1'b1;
        $display("reset test done");
        // Writes wait for the strobe; a strobe held low updates one cycle after the write
        wr(3'h3, 16'h5a3c);
        cyc(6);
        #1 chk("pending", chan[63:48], 16'h0000);
        strobe(4);
        cyc(6);
        #1 chk("loaded", chan[63:48], 16'h5a3c);
        cyc(1);
        ld_n <= 1'b0;
        wr(3'h5, 16'hc3a5);
        cyc(6);
        #1 chk("held low", chan[95:80], 16'hc3a5);
        // With the clock enable low a write is lost, even with the strobe held low
        cyc(1);
        ce <= 1'b0;
        wr(3'h6, 16'h0f0f);
        ce <= 1'b1;
        cyc(6);
        #1 chk("frozen", chan[111:96], 16'h0000);
        cyc(1);
        ld_n <= 1'b1;
        rb <= 1'b1;
        rbc <= 3'h3;
        h.xfer(24'h000000, 24, rx);
        chk("readback", rx, {8'h00, 16'h5a3c});
        pop(24'h000000);
        cyc(1);
        rb <= 1'b0;
        $display("load test done");
        // A second rst_i with the level strap high must come up at midscale
        lvl <= 1'b1;
        cyc(4);
        rst <= 1'b1;
        cyc(3);
        rst <= 1'b0;
        cyc(8);
        #1 chk("power-up", chan, {8{odsl_pkg::MID_SCALE}});
        cyc(1);
        lvl <= 1'b0;
        cyc(4);
        $display("power-up test done");
        span <= 1'b1;
        cyc(6);
        #1 chk("span", span2, 1'b1);
        cyc(1);
        span <= 1'b0;
        cyc(6);
        #1 chk("span", span2, 1'b0);
        $display("span test done");
        end_of_test;
    end
    // Cuts a hang short
    initial begin
        #2ms;
        failures++;
        end_of_test;
    end
endmodule // odsl_core_tb
`default_nettype wire

// ### dv/odsl_host.sv
// Host serial controller model: frames bits into the core, captures its serial output.
// Assumes the bench calls xfer and nothing else drives these pins.
`default_nettype none
module odsl_host (
    output logic sclk_o,
    output logic sync_n_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle: serial clock parked low, frame select high
    initial begin
        sclk_o = 1'b0;
        sync_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    // One frame of n bits, most significant first; rx gathers the returned bits
    task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rx);
        rx = 24'h000000;
        #3 sync_n_o = 1'b0;
        #400;
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b1;
            sdi_o = w[23 - i];
            #160 sclk_o = 1'b0;
            rx = {rx[22:0], sdo_i};
            #160;
        end
        #200 sync_n_o = 1'b1;
        sdi_o = ~sdi_o; // Released line must not keep its last bit
        #800;
    endtask
endmodule // odsl_host
`default_nettype wire
